// [hw/ssr_status_regs.vh]
// Constants for the status register bank: offsets, codes, reset values.
// Assumes a byte-addressed word port with 8 address bits.
`ifndef SSR_STATUS_REGS_VH
`define SSR_STATUS_REGS_VH

// Register byte offsets, one aligned word each.
`define SSR_A_CMD 8'h00
`define SSR_A_PCHR 8'h04
`define SSR_A_PEND 8'h08
`define SSR_A_FMT 8'h0C
`define SSR_A_QSEL 8'h10
`define SSR_A_OUTQ 8'h14
`define SSR_A_ERRQ 8'h18
`define SSR_A_STAT 8'h1C
`define SSR_A_ENA0 8'h20
`define SSR_A_ENA1 8'h24
`define SSR_A_ENA2 8'h28
`define SSR_A_ENA3 8'h2C
`define SSR_A_EVT0 8'h30
`define SSR_A_EVT1 8'h34
`define SSR_A_EVT2 8'h38
`define SSR_A_EVT3 8'h3C

// Command word bit positions.
`define SSR_CMD_CLS 0
`define SSR_CMD_SPRE 1
`define SSR_CMD_QCLR 2
`define SSR_CMD_ECLR 3
`define SSR_CMD_SYSPRE 4
`define SSR_CMD_RST 5

// End-of-parameter field: target register in bits 1:0.
`define SSR_PEND_TGT 1:0

// Radix codes, shared by parser and readback format.
`define SSR_FMT_DEC 2'h0
`define SSR_FMT_HEX 2'h1
`define SSR_FMT_OCT 2'h2
`define SSR_FMT_BIN 2'h3

// Reset values and codes.
`define SSR_REG_RST 16'h0000
`define SSR_ERR_PARAM 8'h01
`define SSR_STD_QYE 2
`endif

// [hw/ssr_status_bank.v]
// Status structure register bank: four event/enable sets, an error
// queue, an enable-parameter parser and a radix readback formatter.
// Assumes a command parser drives the plain register port on CLK_I and
// that event and error inputs come from logic on the same clock.
//
// How it works
// - power-up clears all registers and both queues
// - enable programmed with zero clears it
// - system preset and reset leave status alone
// - clear-status clears all four event registers
// - status preset clears three enable registers
// - clear-status empties the error queue
// - both queue-clear commands empty error queue
// - standard enable cleared only by zero write
// - status preset keeps the error queue
// - only enable registers are writable
// - parameter sets each bit, four notations
// - registers are 16 bits, bit n weighs 2^n
// - hash header picks radix, any case letter
// - no header means decimal
// - digits limited to the chosen radix
// - query returns register value showing set bits
// - readback radix selectable, decimal by default
// - non-decimal readback carries matching header
// - event bits latch until cleared
// - summary high when enabled event bit set
// - reading standard event register clears it
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "ssr_status_regs.vh"

module ssr_status_bank #(
  parameter EQ_AW = 3, // Error queue address width.
  parameter OQ_AW = 5 // Output queue address width.
) (
  input wire CLK_I,
  input wire RST_B_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  input wire [15:0] EVT_STD_I,
  input wire [15:0] EVT_OPER_I,
  input wire [15:0] EVT_MEAS_I,
  input wire [15:0] EVT_QUES_I,
  input wire ERR_PUSH_I,
  input wire [7:0] ERR_CODE_I,
  output wire [3:0] SUM_O,
  output wire EAV_O,
  output wire MAV_O,
  output wire FMT_BUSY_O
);

  ////////////////////////////////////////////////////////////////////////
  // Decode and register state.

  wire wr_cmd = WR_I && (ADDR_I == `SSR_A_CMD); // Command strobe.
  wire wr_chr = WR_I && (ADDR_I == `SSR_A_PCHR); // Parameter character.
  wire wr_end = WR_I && (ADDR_I == `SSR_A_PEND); // Parameter commit.
  wire wr_fmt = WR_I && (ADDR_I == `SSR_A_FMT); // Format select.
  wire wr_qsel = WR_I && (ADDR_I == `SSR_A_QSEL); // Start a query.
  wire rd_outq = RD_I && (ADDR_I == `SSR_A_OUTQ); // Pop response char.
  wire rd_errq = RD_I && (ADDR_I == `SSR_A_ERRQ); // Pop error code.
  wire rd_evt0 = RD_I && (ADDR_I == `SSR_A_EVT0); // Standard event read.

  // Command decode; system preset and reset have no action here.
  wire c_cls = wr_cmd && WDATA_I[`SSR_CMD_CLS];
  wire c_spre = wr_cmd && WDATA_I[`SSR_CMD_SPRE];
  wire c_eclr = wr_cmd && (WDATA_I[`SSR_CMD_QCLR] ||
    WDATA_I[`SSR_CMD_ECLR]);

  reg [15:0] ena_r [0:3]; // Enable registers: std, oper, meas, ques.
  reg [15:0] evt_r [0:3]; // Latched event registers.
  reg [1:0] fmt_r; // Readback radix.
  wire [15:0] evt_in [0:3]; // Event pulses, per set.
  assign evt_in[0] = EVT_STD_I;
  assign evt_in[1] = EVT_OPER_I;
  assign evt_in[2] = EVT_MEAS_I;
  assign evt_in[3] = EVT_QUES_I;
  reg fq_clr; // Query of the standard event register clears it.
  reg [1:0] fq_src; // Event set being queried.
  reg [OQ_AW:0] oq_wp_r; // Output queue write pointer.
  reg [OQ_AW:0] oq_rp_r; // Output queue read pointer.
  wire oq_empty = (oq_wp_r == oq_rp_r);
  wire oq_qye = rd_outq && oq_empty; // Read of an empty queue.

  ////////////////////////////////////////////////////////////////////////
  // Enable parameter parser.

  localparam P_START = 2'h0; // Nothing seen yet.
  localparam P_HASH = 2'h1; // Hash seen, header letter next.
  localparam P_DIG = 2'h2; // Collecting digits.

  reg [1:0] p_st_r; // Parser state.
  reg [1:0] p_rad_r; // Radix of the value being parsed.
  reg [15:0] p_acc_r; // Accumulated value.
  reg p_bad_r; // Any illegal character or overflow.
  reg p_any_r; // At least one digit seen.
  wire [7:0] ch = WDATA_I[7:0];
  wire [7:0] ch_lc = ch | 8'h20; // Folded to lower case.
  reg [4:0] dv; // Digit value, 16 means not a digit.
  reg [4:0] base; // Numeric base of the current radix.

  // Digit value and base; the base bounds which digits are legal.
  always @* begin
    if (ch >= "0" && ch <= "9")
      dv = ch[4:0] - 5'h10;
    else if (ch_lc >= "a" && ch_lc <= "f")
      dv = ch_lc[4:0] + 5'h09;
    else
      dv = 5'h10;
    case (p_rad_r)
      `SSR_FMT_HEX: base = 5'h10;
      `SSR_FMT_OCT: base = 5'h08;
      `SSR_FMT_BIN: base = 5'h02;
      default: base = 5'h0A;
    endcase
  end

  wire dig_ok = (dv < base);
  wire [21:0] p_sum = p_acc_r * base + {17'h0, dv};
  wire p_ovf = |p_sum[21:16]; // Value above 16 bits.
  wire p_err = wr_end && (p_bad_r || !p_any_r);
  wire p_ok = wr_end && !p_bad_r && p_any_r;
  wire [1:0] p_tgt = WDATA_I[`SSR_PEND_TGT];

  // Header and digit handling; a commit always restarts the parser.
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      p_st_r <= P_START;
      p_rad_r <= `SSR_FMT_DEC;
      p_acc_r <= `SSR_REG_RST;
      p_bad_r <= 1'b0;
      p_any_r <= 1'b0;
    end else if (wr_end) begin
      p_st_r <= P_START;
      p_rad_r <= `SSR_FMT_DEC;
      p_acc_r <= `SSR_REG_RST;
      p_bad_r <= 1'b0;
      p_any_r <= 1'b0;
    end else if (wr_chr) begin
      case (p_st_r)
        P_START: begin
          if (ch == "#") begin
            p_st_r <= P_HASH;
          end else begin
            // No header: the value is decimal.
            p_st_r <= P_DIG;
            p_acc_r <= p_sum[15:0];
            p_bad_r <= !dig_ok || p_ovf;
            p_any_r <= 1'b1;
          end
        end
        P_HASH: begin
          p_st_r <= P_DIG;
          // Header letter accepted in either case.
          if (ch_lc == "b")
            p_rad_r <= `SSR_FMT_BIN;
          else if (ch_lc == "h")
            p_rad_r <= `SSR_FMT_HEX;
          else if (ch_lc == "q")
            p_rad_r <= `SSR_FMT_OCT;
          else
            p_bad_r <= 1'b1;
        end
        P_DIG: begin
          // Each digit shifts the value in its own radix.
          p_acc_r <= p_sum[15:0];
          p_any_r <= 1'b1;
          if (!dig_ok || p_ovf)
            p_bad_r <= 1'b1;
        end
        default: p_st_r <= P_START;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable and event registers.

  integer i;

  // Only enables are writable; a commit of zero clears the target.
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (i = 0; i < 4; i = i + 1) begin
        ena_r[i] <= `SSR_REG_RST;
        evt_r[i] <= `SSR_REG_RST;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        // Status preset spares the standard enable.
        if (p_ok && p_tgt == i[1:0])
          ena_r[i] <= p_acc_r;
        else if (c_spre && i != 0)
          ena_r[i] <= `SSR_REG_RST;
        // An event arriving with a clear still lands.
        if (c_cls || (rd_evt0 && i == 0) || (fq_clr && fq_src == i))
          evt_r[i] <= evt_in[i];
        else
          evt_r[i] <= evt_r[i] | evt_in[i];
      end
      if (oq_qye)
        evt_r[0][`SSR_STD_QYE] <= 1'b1;
    end
  end

  // Summaries follow the registers, they do not latch.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : sum_gen
      assign SUM_O[g] = |(evt_r[g] & ena_r[g]);
    end
  endgenerate

  // Readback format, decimal after reset.
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I)
      fmt_r <= `SSR_FMT_DEC;
    else if (wr_fmt)
      fmt_r <= WDATA_I[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Error queue.

  reg [7:0] eq_mem [0:(1<<EQ_AW)-1]; // Error codes.
  reg [EQ_AW:0] eq_wp_r; // Write pointer, one spare bit.
  reg [EQ_AW:0] eq_rp_r; // Read pointer, one spare bit.
  wire [EQ_AW:0] eq_cnt = eq_wp_r - eq_rp_r;
  wire eq_full = eq_cnt[EQ_AW];
  wire eq_empty = (eq_cnt == {(EQ_AW+1){1'b0}});
  // A parse error takes the slot over an outside error that cycle.
  wire eq_push = p_err || ERR_PUSH_I;
  wire [7:0] eq_code = p_err ? `SSR_ERR_PARAM : ERR_CODE_I;
  assign EAV_O = !eq_empty;

  // Clear empties the queue, but a push in that cycle is kept.
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      eq_wp_r <= {(EQ_AW+1){1'b0}};
      eq_rp_r <= {(EQ_AW+1){1'b0}};
    end else if (c_cls || c_eclr) begin
      eq_rp_r <= eq_wp_r;
      if (eq_push)
        eq_wp_r <= eq_wp_r + 1'b1;
    end else begin
      if (eq_push && !eq_full)
        eq_wp_r <= eq_wp_r + 1'b1;
      if (rd_errq && !eq_empty)
        eq_rp_r <= eq_rp_r + 1'b1;
    end
  end

  // Queue storage; a full queue drops new codes.
  always @(posedge CLK_I) begin
    if (eq_push && (!eq_full || c_cls || c_eclr))
      eq_mem[eq_wp_r[EQ_AW-1:0]] <= eq_code;
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback formatter and output queue.

  localparam F_IDLE = 2'h0; // Waiting for a query.
  localparam F_HDR = 2'h1; // Emitting the hash.
  localparam F_LET = 2'h2; // Emitting the header letter.
  localparam F_DIG = 2'h3; // Emitting digits.

  reg [1:0] f_st_r; // Formatter state.
  reg [1:0] f_rad_r; // Radix taken at query start.
  reg [15:0] f_val_r; // Value being converted.
  reg [3:0] f_idx_r; // Digit group or decimal place index.
  reg [3:0] f_cnt_r; // Decimal digit being counted.
  reg f_lead_r; // A nonzero digit has been emitted.
  reg [7:0] oq_mem [0:(1<<OQ_AW)-1]; // Response characters.
  assign MAV_O = !oq_empty;
  assign FMT_BUSY_O = (f_st_r != F_IDLE);

  // Query start: source 0-3 are enables, 4-7 event registers.
  always @* begin
    fq_src = WDATA_I[1:0];
    fq_clr = wr_qsel && WDATA_I[2] && (WDATA_I[1:0] == 2'h0);
  end

  reg [15:0] pw; // Decimal place weight.
  reg [3:0] gd; // Current digit; in decimal it is the count f_cnt_r.
  reg [3:0] last; // Index of the least significant group.
  reg [7:0] f_ch; // Character to emit.
  reg f_emit; // Emit f_ch this cycle.

  // Digit extraction: shifts for powers of two, subtraction for tens.
  always @* begin
    case (f_idx_r)
      4'h0: pw = 16'h2710;
      4'h1: pw = 16'h03E8;
      4'h2: pw = 16'h0064;
      4'h3: pw = 16'h000A;
      default: pw = 16'h0001;
    endcase
    case (f_rad_r)
      `SSR_FMT_HEX: gd = f_val_r[15:12];
      // Sixteen bits split as one top bit, then five groups of three.
      `SSR_FMT_OCT: gd = (f_idx_r == 4'h0) ? {3'h0, f_val_r[15]} :
        {1'b0, f_val_r[15:13]};
      `SSR_FMT_BIN: gd = {3'h0, f_val_r[15]};
      default: gd = f_cnt_r;
    endcase
    case (f_rad_r)
      `SSR_FMT_HEX: last = 4'h3;
      `SSR_FMT_OCT: last = 4'h5;
      `SSR_FMT_BIN: last = 4'hF;
      default: last = 4'h4;
    endcase
    f_ch = (gd < 4'hA) ? {4'h3, gd} : {4'h4, gd - 4'h9};
    f_emit = 1'b0;
    case (f_st_r)
      F_HDR: begin
        f_ch = "#";
        f_emit = 1'b1;
      end
      F_LET: begin
        f_ch = (f_rad_r == `SSR_FMT_HEX) ? "H" :
          (f_rad_r == `SSR_FMT_OCT) ? "Q" : "B";
        f_emit = 1'b1;
      end
      F_DIG: begin
        // Leading zeros are dropped; the last digit always shows.
        if (f_rad_r != `SSR_FMT_DEC || f_val_r < pw)
          f_emit = f_lead_r || gd != 4'h0 || f_idx_r == last;
      end
      default: f_emit = 1'b0;
    endcase
  end

  // Formatter sequencer; a new query replaces any unread response.
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      f_st_r <= F_IDLE;
      f_rad_r <= `SSR_FMT_DEC;
      f_val_r <= `SSR_REG_RST;
      f_idx_r <= 4'h0;
      f_cnt_r <= 4'h0;
      f_lead_r <= 1'b0;
    end else if (wr_qsel) begin
      // Value and radix are caught at the query.
      f_val_r <= WDATA_I[2] ? evt_r[fq_src] : ena_r[fq_src];
      f_rad_r <= fmt_r;
      f_st_r <= (fmt_r == `SSR_FMT_DEC) ? F_DIG : F_HDR;
      f_idx_r <= 4'h0;
      f_cnt_r <= 4'h0;
      f_lead_r <= 1'b0;
    end else begin
      case (f_st_r)
        F_HDR: f_st_r <= F_LET;
        F_LET: f_st_r <= F_DIG;
        F_DIG: begin
          if (f_emit)
            f_lead_r <= 1'b1;
          if (f_rad_r == `SSR_FMT_DEC && f_val_r >= pw) begin
            f_val_r <= f_val_r - pw;
            f_cnt_r <= f_cnt_r + 4'h1;
          end else begin
            f_cnt_r <= 4'h0;
            f_idx_r <= f_idx_r + 4'h1;
            if (f_idx_r == last)
              f_st_r <= F_IDLE;
            case (f_rad_r)
              `SSR_FMT_HEX: f_val_r <= {f_val_r[11:0], 4'h0};
              `SSR_FMT_OCT: f_val_r <= (f_idx_r == 4'h0) ?
                {f_val_r[14:0], 1'b0} : {f_val_r[12:0], 3'h0};
              `SSR_FMT_BIN: f_val_r <= {f_val_r[14:0], 1'b0};
              default: f_val_r <= f_val_r;
            endcase
          end
        end
        default: f_st_r <= F_IDLE;
      endcase
    end
  end

  // Output queue pointers; a query flushes the old response.
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      oq_wp_r <= {(OQ_AW+1){1'b0}};
      oq_rp_r <= {(OQ_AW+1){1'b0}};
    end else if (wr_qsel) begin
      oq_rp_r <= oq_wp_r;
    end else begin
      if (f_emit)
        oq_wp_r <= oq_wp_r + 1'b1;
      if (rd_outq && !oq_empty)
        oq_rp_r <= oq_rp_r + 1'b1;
    end
  end

  // Response storage; the longest response fits the default depth.
  always @(posedge CLK_I) begin
    if (f_emit && !wr_qsel)
      oq_mem[oq_wp_r[OQ_AW-1:0]] <= f_ch;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle after the strobe.

  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= 32'h00000000;
    end else if (RD_I) begin
      case (ADDR_I)
        `SSR_A_FMT: RDATA_O <= {30'h0, fmt_r};
        `SSR_A_OUTQ: RDATA_O <= oq_empty ? 32'h00000000 :
          {23'h0, 1'b1, oq_mem[oq_rp_r[OQ_AW-1:0]]};
        `SSR_A_ERRQ: RDATA_O <= eq_empty ? 32'h00000000 :
          {23'h0, 1'b1, eq_mem[eq_rp_r[EQ_AW-1:0]]};
        `SSR_A_STAT: RDATA_O <= {20'h0, eq_cnt[3:0], 1'b0,
          FMT_BUSY_O, MAV_O, EAV_O, SUM_O};
        `SSR_A_ENA0: RDATA_O <= {16'h0, ena_r[0]};
        `SSR_A_ENA1: RDATA_O <= {16'h0, ena_r[1]};
        `SSR_A_ENA2: RDATA_O <= {16'h0, ena_r[2]};
        `SSR_A_ENA3: RDATA_O <= {16'h0, ena_r[3]};
        `SSR_A_EVT0: RDATA_O <= {16'h0, evt_r[0]};
        `SSR_A_EVT1: RDATA_O <= {16'h0, evt_r[1]};
        `SSR_A_EVT2: RDATA_O <= {16'h0, evt_r[2]};
        `SSR_A_EVT3: RDATA_O <= {16'h0, evt_r[3]};
        default: RDATA_O <= 32'h00000000;
      endcase
    end else begin
      RDATA_O <= 32'h00000000;
    end
  end

endmodule

// [dv/ssr_ctl_model.sv]
// Model of the controller side that raises instrument events and errors.
// Assumes the bench calls its tasks and that it shares the bank's clock.
`timescale 1ns/10ps

module ssr_ctl_model (
  input wire clk_i,
  output logic [15:0] evt_std_o,
  output logic [15:0] evt_oper_o,
  output logic [15:0] evt_meas_o,
  output logic [15:0] evt_ques_o,
  output logic err_push_o,
  output logic [7:0] err_code_o
);
  // All lines idle at zero, so no event is seen before it is asked for.
  initial begin
    evt_std_o = 16'h0000;
    evt_oper_o = 16'h0000;
    evt_meas_o = 16'h0000;
    evt_ques_o = 16'h0000;
    err_push_o = 1'b0;
    err_code_o = 8'h00;
  end

  // One-cycle event pulse on one set; the bank must latch it itself.
  task pulse(input int s, input logic [15:0] b);
    begin
      @(posedge clk_i);
      case (s)
        0: evt_std_o <= b;
        1: evt_oper_o <= b;
        2: evt_meas_o <= b;
        default: evt_ques_o <= b;
      endcase
      @(posedge clk_i);
      evt_std_o <= 16'h0000;
      evt_oper_o <= 16'h0000;
      evt_meas_o <= 16'h0000;
      evt_ques_o <= 16'h0000;
    end
  endtask

  // One-cycle push; the code is changed afterwards so a stale read shows.
  task push(input logic [7:0] c);
    begin
      @(posedge clk_i);
      err_push_o <= 1'b1;
      err_code_o <= c;
      @(posedge clk_i);
      err_push_o <= 1'b0;
      err_code_o <= ~c;
    end
  endtask
endmodule

// [dv/ssr_status_bank_assertions.sv]
// Checker for the status bank, watching only the bank's ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
`include "ssr_status_regs.vh"

module ssr_status_bank_chk (
  input wire CLK_I,
  input wire RST_B_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  input wire [15:0] EVT_STD_I,
  input wire [15:0] EVT_OPER_I,
  input wire [15:0] EVT_MEAS_I,
  input wire [15:0] EVT_QUES_I,
  input wire ERR_PUSH_I,
  input wire [7:0] ERR_CODE_I,
  input wire [3:0] SUM_O,
  input wire EAV_O,
  input wire MAV_O,
  input wire FMT_BUSY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  // No event arrives this cycle, so set-wins-over-clear cannot mask a fault.
  wire quiet = ~|{EVT_STD_I, EVT_OPER_I, EVT_MEAS_I, EVT_QUES_I};

  ////////////////////////////////////////////////////////////////////////////
  // Named steps of the command and read cycles.
  sequence s_cmd(int b);
    WR_I && ADDR_I == `SSR_A_CMD && WDATA_I[b];
  endsequence
  sequence s_std_rd;
    RD_I && ADDR_I == `SSR_A_EVT0 && EVT_STD_I == 16'h0000;
  endsequence
  sequence s_no_pop;
    !ERR_PUSH_I && !(RD_I && ADDR_I == `SSR_A_ERRQ);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Relations between commands, reads and the status outputs.
  a_rdata_idle_zero: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data not zero outside a read answer");
  a_cls_events_clr: assert property (s_cmd(0) ##0 quiet |=> SUM_O == 4'h0)
    else $error("summary still set after clear status");
  a_cls_errq_empty: assert property (s_cmd(0) ##0 !ERR_PUSH_I |=> !EAV_O)
    else $error("error queue not empty after clear status");
  a_qclr_errq_empty: assert property
    ((s_cmd(2) or s_cmd(3)) ##0 !ERR_PUSH_I |=> !EAV_O)
    else $error("error queue not empty after queue clear");
  a_preset_ena_clr: assert property (s_cmd(1) |=> SUM_O[3:1] == 3'h0)
    else $error("enable summary kept after status preset");
  a_preset_keeps_err: assert property
    (s_cmd(1) ##0 WDATA_I[3:0] == 4'h2 ##0 s_no_pop ##0 EAV_O |=> EAV_O)
    else $error("status preset lost the error queue");
  a_sys_rst_keep: assert property
    (WR_I && ADDR_I == `SSR_A_CMD && WDATA_I[5:0] == 6'h30 && quiet &&
     !ERR_PUSH_I |=> $stable(SUM_O) && $stable(EAV_O))
    else $error("system preset or reset changed status");
  a_event_latched: assert property (SUM_O[3] && !WR_I |=> SUM_O[3])
    else $error("latched event summary dropped");
  a_std_read_clr: assert property (s_std_rd |=> !SUM_O[0])
    else $error("standard summary kept after event read");
  a_fmt_done_bound: assert property ($rose(FMT_BUSY_O) |-> ##[1:300] !FMT_BUSY_O)
    else $error("formatter busy too long");
endmodule

bind ssr_status_bank ssr_status_bank_chk u_chk (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .EVT_STD_I(EVT_STD_I),
  .EVT_OPER_I(EVT_OPER_I), .EVT_MEAS_I(EVT_MEAS_I), .EVT_QUES_I(EVT_QUES_I),
  .ERR_PUSH_I(ERR_PUSH_I), .ERR_CODE_I(ERR_CODE_I), .SUM_O(SUM_O),
  .EAV_O(EAV_O), .MAV_O(MAV_O), .FMT_BUSY_O(FMT_BUSY_O)
);

// [dv/status_register_clear_and_format_test.sv]
// Self-checking bench for the status bank over its plain register port.
// Assumes the bank, its constants header and the controller model.
`timescale 1ns/10ps
`include "ssr_status_regs.vh"

module status_register_clear_and_format_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire [31:0] rdata;
  wire [15:0] e_std, e_oper, e_meas, e_ques;
  wire push;
  wire [7:0] code;
  wire [3:0] sum;
  wire eav, mav, busy;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] d; // Last word read.
  logic [15:0] ena [4]; // Expected enable contents.
  // Good parameters: text, target set, value.
  string gs [8] = '{"#b101100", "#H2C", "#q54", "44", "#B1000000000000000",
                    "32768", "#hffff", "#Q177777"};
  logic [15:0] gv [8] = '{16'h002C, 16'h002C, 16'h002C, 16'h002C,
                          16'h8000, 16'h8000, 16'hFFFF, 16'hFFFF};
  string bs [4] = '{"#b102", "#q8", "#hG", "65536"}; // Refused texts.
  string qs [4] = '{"44", "#H2C", "#Q54", "#B101100"}; // Readback per radix.

  always #10 clk = ~clk;

  ssr_ctl_model src (.clk_i(clk), .evt_std_o(e_std), .evt_oper_o(e_oper),
    .evt_meas_o(e_meas), .evt_ques_o(e_ques), .err_push_o(push),
    .err_code_o(code));
  ssr_status_bank uut (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .EVT_STD_I(e_std), .EVT_OPER_I(e_oper), .EVT_MEAS_I(e_meas),
    .EVT_QUES_I(e_ques), .ERR_PUSH_I(push), .ERR_CODE_I(code), .SUM_O(sum),
    .EAV_O(eav), .MAV_O(mav), .FMT_BUSY_O(busy));

  ////////////////////////////////////////////////////////////////////////////
  // Closing report, comparison and bus cycles.
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp) begin
        fail_count++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // One-cycle write strobe.
  task wrw(input logic [7:0] a, input logic [31:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  // One-cycle read strobe; data is taken in the cycle after it.
  task rdw(input logic [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask

  // Sends a parameter one character at a time, then commits it.
  task prm(input string s, input int t);
    begin
      for (int i = 0; i < s.len(); i++) wrw(`SSR_A_PCHR, {24'h0, s[i]});
      wrw(`SSR_A_PEND, t);
    end
  endtask

  task chk_ena;
    begin
      for (int i = 0; i < 4; i++) begin
        rdw(`SSR_A_ENA0 + 4 * i);
        chk("enable", d, {16'h0, ena[i]});
      end
    end
  endtask

  // Starts a query of enable set 1 and collects the response text.
  task qry(input string s);
    int n;
    begin
      wrw(`SSR_A_QSEL, 32'h1);
      @(posedge clk);
      n = 0;
      #1;
      while (busy !== 1'b0 && n < 400) begin
        @(posedge clk);
        #1 n++;
      end
      if (n >= 400) begin
        fail_count++;
        give_verdict;
      end
      rdw(`SSR_A_STAT);
      chk("reply ready", d[5], 1'b1);
      for (int i = 0; i < s.len(); i++) begin
        rdw(`SSR_A_OUTQ);
        chk("reply char", d, {23'h0, 1'b1, s[i]});
      end
      rdw(`SSR_A_OUTQ);
      chk("reply end", d, 32'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // Popping the empty reply queue would set the query error bit,
    // so only the status places are read here.
    for (int i = 0; i < 10; i++) begin
      rdw(`SSR_A_ERRQ + 4 * i);
      chk("after power-up", d, 32'h0);
    end
    rdw(`SSR_A_FMT);
    chk("format default", d, 32'h0);
    // Every notation and header case; top bit weight and full range.
    for (int i = 0; i < 8; i++) begin
      prm(gs[i], i % 4);
      ena[i % 4] = gv[i];
    end
    chk_ena;
    // Digits outside the radix and overflow are refused with an error.
    foreach (bs[i]) begin
      prm(bs[i], i);
      rdw(`SSR_A_ERRQ);
      chk("param error", d, {23'h0, 1'b1, `SSR_ERR_PARAM});
    end
    chk_ena;
    // Direct writes to enable and event places are ignored.
    wrw(`SSR_A_ENA0, 32'h1234);
    wrw(`SSR_A_EVT0, 32'h1234);
    chk_ena;
    rdw(`SSR_A_EVT0);
    chk("event write", d, 32'h0);
    // Readback in each radix; an empty pop after each sets query error.
    prm("#h2C", 1);
    ena[1] = 16'h002C;
    for (int f = 0; f < 4; f++) begin
      wrw(`SSR_A_FMT, f);
      rdw(`SSR_A_FMT);
      chk("format", d, f);
      qry(qs[f]);
    end
    // System preset and reset leave status and queues alone.
    src.push(8'h5A);
    wrw(`SSR_A_CMD, 32'h30);
    chk_ena;
    rdw(`SSR_A_STAT);
    chk("error pending", d[4], 1'b1);
    // Latched event and its summary; standard read clears.
    src.pulse(3, 16'h0004);
    repeat (2) begin
      rdw(`SSR_A_EVT3);
      chk("latched event", d, 32'h4);
    end
    rdw(`SSR_A_STAT);
    chk("summary", d[3:0], 4'h8);
    rdw(`SSR_A_EVT0);
    chk("query error", d, 32'h4);
    rdw(`SSR_A_EVT0);
    chk("std after read", d, 32'h0);
    // Status preset: three enables cleared, std enable and queue kept.
    wrw(`SSR_A_CMD, 32'h2);
    ena[1] = 16'h0;
    ena[2] = 16'h0;
    ena[3] = 16'h0;
    chk_ena;
    rdw(`SSR_A_STAT);
    chk("error kept", d[4], 1'b1);
    // Clear status: events and error queue emptied, std enable kept.
    wrw(`SSR_A_CMD, 32'h1);
    rdw(`SSR_A_EVT3);
    chk("event cleared", d, 32'h0);
    rdw(`SSR_A_STAT);
    chk("error cleared", d[4], 1'b0);
    chk_ena;
    // Both queue clear commands empty the error queue.
    for (int b = 2; b < 4; b++) begin
      src.push(8'h33);
      wrw(`SSR_A_CMD, 32'h1 << b);
      rdw(`SSR_A_ERRQ);
      chk("queue clear", d, 32'h0);
    end
    // A zero parameter clears the standard enable completely.
    prm("0", 0);
    ena[0] = 16'h0;
    chk_ena;
    give_verdict;
  end
endmodule
